//--- rtcc_pkg.sv
package rtcc_pkg;

  // Timing of one prescaler step, 1/128 s
  localparam int CLK_PERIOD_NS  = 10;
  localparam int STEP_PERIOD_NS = 7812500;
  localparam int STEP_CYCLES    = STEP_PERIOD_NS / CLK_PERIOD_NS;
  localparam int STEP_CNT_W     = 20;

  // Bus geometry
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [5:0] OFS_PRESCALER = 6'h00;
  localparam logic [5:0] OFS_SECONDS   = 6'h04;
  localparam logic [5:0] OFS_MINUTES   = 6'h08;
  localparam logic [5:0] OFS_HOURS     = 6'h0C;
  localparam logic [5:0] OFS_WEEKDAY   = 6'h10;
  localparam logic [5:0] OFS_DATE      = 6'h14;
  localparam logic [5:0] OFS_MONTH     = 6'h18;
  localparam logic [5:0] OFS_YEAR      = 6'h1C;
  localparam logic [5:0] OFS_CONTROL   = 6'h20;

  // Writable bits of each counter
  localparam logic [7:0] MASK_SEC   = 8'h7F;
  localparam logic [7:0] MASK_MIN   = 8'h7F;
  localparam logic [7:0] MASK_HOUR  = 8'h3F;
  localparam logic [7:0] MASK_WEEK  = 8'h07;
  localparam logic [7:0] MASK_DATE  = 8'h3F;
  localparam logic [7:0] MASK_MONTH = 8'h1F;
  localparam logic [7:0] MASK_YEAR  = 8'hFF;

  // Counter limits in packed BCD
  localparam logic [7:0] BCD_ZERO  = 8'h00;
  localparam logic [7:0] BCD_ONE   = 8'h01;
  localparam logic [7:0] SEC_MAX   = 8'h59;
  localparam logic [7:0] SEC_HALF  = 8'h30;
  localparam logic [7:0] MIN_MAX   = 8'h59;
  localparam logic [7:0] HOUR_MAX  = 8'h23;
  localparam logic [7:0] WEEK_MAX  = 8'h06;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX  = 8'h99;
  localparam logic [7:0] DAYS_31   = 8'h31;
  localparam logic [7:0] DAYS_30   = 8'h30;
  localparam logic [7:0] DAYS_29   = 8'h29;
  localparam logic [7:0] DAYS_28   = 8'h28;
  localparam logic [7:0] MON_FEB   = 8'h02;
  localparam logic [7:0] MON_APR   = 8'h04;
  localparam logic [7:0] MON_JUN   = 8'h06;
  localparam logic [7:0] MON_SEP   = 8'h09;
  localparam logic [7:0] MON_NOV   = 8'h11;
  localparam logic [3:0] DIGIT_NINE = 4'h9;
  localparam logic [3:0] DIGIT_ZERO = 4'h0;
  localparam logic [3:0] DIGIT_ONE  = 4'h1;

  // Control register fields
  localparam int         CTL_RUN_BIT    = 0;
  localparam int         CTL_CLKRST_BIT = 1;
  localparam int         CTL_ROUND_BIT  = 2;
  localparam logic       CTL_RUN_RESET  = 1'b1;

  // Prescaler view
  localparam int         PRE_W    = 7;
  localparam logic [6:0] PRE_FULL = 7'h7F;
  localparam logic [6:0] PRE_ZERO = 7'h00;
  localparam logic [6:0] PRE_ONE  = 7'h01;

  // Bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } rtcc_bus_e;

  // Packed BCD plus one, no range check
  function automatic logic [7:0] rtcc_bcd_inc(input logic [7:0] v);
    if (v[3:0] == DIGIT_NINE) begin
      return {v[7:4] + DIGIT_ONE, DIGIT_ZERO};
    end
    return {v[7:4], v[3:0] + DIGIT_ONE};
  endfunction

  // One counter step: carry out in bit 8, wrap to lowest at highest
  function automatic logic [8:0] rtcc_step(input logic [7:0] v,
                                           input logic [7:0] hi,
                                           input logic [7:0] lo);
    if (v == hi) begin
      return {1'b1, lo};
    end
    return {1'b0, rtcc_bcd_inc(v)};
  endfunction

  // Year multiple of four: 10*t+u mod 4 equals 2*t+u mod 4
  function automatic logic rtcc_is_leap(input logic [7:0] yr);
    logic [3:0] s;
    s = {2'b00, yr[4], 1'b0} + yr[3:0];
    return (s[1:0] == 2'b00);
  endfunction

  // Last date of a month
  function automatic logic [7:0] rtcc_last_day(input logic [7:0] mon,
                                               input logic       leap);
    if (mon == MON_FEB) begin
      return leap ? DAYS_29 : DAYS_28;
    end
    if (mon == MON_APR || mon == MON_JUN || mon == MON_SEP || mon == MON_NOV) begin
      return DAYS_30;
    end
    return DAYS_31;
  endfunction

endpackage

//--- rtcc_pre_if.sv
`timescale 1ns/100ps
// Link between the calendar core and the prescaler
interface rtcc_pre_if;
  logic         run;    // Count enable
  logic         clear;  // Clear prescaler, one-cycle pulse
  logic         carry;  // Once-per-second carry, one-cycle pulse
  logic [6:0]   view;   // Divider stages 1 Hz..64 Hz
  modport ctrl (output run, output clear, input carry, input view);
  modport pre  (input run, input clear, output carry, output view);
endinterface

//--- rtcc_prescaler.sv
`timescale 1ns/100ps
module rtcc_prescaler
  import rtcc_pkg::*;
#(
  parameter int STEP_CYCLES_P = STEP_CYCLES
) (
  input  wire logic  clk,
  input  wire logic  arst_n,
  rtcc_pre_if.pre    pif
);

  logic [STEP_CNT_W-1:0] step_cnt;  // Cycles within one 1/128 s step
  logic                  step;      // One step elapsed
  logic [PRE_W-1:0]      view;      // Divider stages, kept over reset

  // Step strobe only while counting
  assign step = pif.run && (step_cnt == STEP_CNT_W'(STEP_CYCLES_P - 1));

  // Step divider; bus-side logic, so reset is fine here
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      step_cnt <= '0;
    end else if (pif.clear || step) begin
      // Clear restarts a full step so the first second is whole
      step_cnt <= '0;
    end else if (pif.run) begin
      step_cnt <= step_cnt + STEP_CNT_W'(1);
    end
  end

  // Stage view: no reset, survives power-on and manual reset
  always_ff @(posedge clk) begin
    if (pif.clear) begin
      view <= PRE_ZERO;
    end else if (step) begin
      view <= view + PRE_ONE;
    end
  end

  // Carry once per second when all stages roll over
  assign pif.carry = step && (view == PRE_FULL);
  assign pif.view  = view;

endmodule

//--- rtcc_counter_chain.sv
`timescale 1ns/100ps
// How it works
// - Eight-bit read-only stage view, top bit zero
// - Clock-reset or rounding write clears stage view
// - Counters and stage view survive the arst_n reset
// - Counters hold packed BCD, units low
// - Seconds count per prescaler carry, 00-59
// - Minutes count per seconds carry, 00-59
// - Hours count per minutes carry, 00-23
// - Weekday counts per day, Sunday 0..Saturday 6
// - Date counts per day carry, 01-31
// - Last date follows month and leap year
// - Month counts per date carry, to 12
// - Year holds two digits, 00-99
// - Year multiple of four is leap, 00 included
module rtcc_counter_chain
  import rtcc_pkg::*;
#(
  parameter int STEP_CYCLES_P = STEP_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest
);

  // Bus handshake. Every access costs exactly one wait cycle, which
  // gives the read mux a full cycle before the data is registered;
  // the price is half the bus rate, harmless for a clock block
  rtcc_bus_e   bus_state;   // One wait state per access
  rtcc_bus_e   next_bus_state;
  logic        req;         // Read or write pending
  logic        fire;        // Access completes this edge
  logic        wr_fire;     // Write takes effect this edge
  logic [7:0]  wbyte;       // Low write byte
  logic [7:0]  rd_val;      // Addressed register value
  logic        ctl_wr;      // Write to the control register lands

  // Control. The action bits are pulses, not stored state, so they
  // can never stay set and hold the stage view cleared
  logic        run;         // Counting enabled
  logic        clk_rst;     // Clock-reset write pulse
  logic        round;       // Half-minute rounding write pulse

  // Calendar counters, packed BCD. Storage keeps all eight bits; the
  // masks on write and read make the unused bits read zero
  logic [7:0]  seconds_bcd;
  logic [7:0]  minutes_bcd;
  logic [7:0]  hours_bcd;
  logic [7:0]  weekday_code;
  logic [7:0]  date_bcd;
  logic [7:0]  month_bcd;
  logic [7:0]  year_bcd;

  // Next values, the single source of every counter update
  // (carry, rounding or software write)
  logic [7:0]  next_seconds;
  logic [7:0]  next_minutes;
  logic [7:0]  next_hours;
  logic [7:0]  next_weekday;
  logic [7:0]  next_date;
  logic [7:0]  next_month;
  logic [7:0]  next_year;

  // Carries between counters; each is high for one cycle at most
  // and feeds only the next counter up, except day_in, which feeds weekday and date
  logic        sec_in;      // Into seconds
  logic        min_in;      // Into minutes
  logic        hour_in;     // Into hours
  logic        day_in;      // Into weekday and date
  logic        mon_in;      // Into month
  logic        yr_in;       // Into year
  logic        leap;        // Current year is leap
  logic [7:0]  last_day;    // Last date of current month

  // Link to the prescaler
  rtcc_pre_if  pif ();

  // Prescaler with its divider. It owns the stage view so that the
  // clear and the count can never fight over the same flip-flops
  rtcc_prescaler #(
    .STEP_CYCLES_P (STEP_CYCLES_P)
  ) u_prescaler (
    .clk    (clk),
    .arst_n (arst_n),
    .pif    (pif)
  );

  // Run gates the divider, clears come from either action pulse
  assign pif.run   = run;
  // Either control bit clears the stages
  assign pif.clear = clk_rst || round;

  // Request and strobes
  assign req     = avs_read || avs_write;
  assign fire    = req && (bus_state == BUS_DONE);
  assign wr_fire = fire && avs_write && avs_byteenable[0];
  assign wbyte   = avs_writedata[7:0];
  // Control decode shared by the run bit and the action pulses
  assign ctl_wr  = wr_fire && (avs_address == OFS_CONTROL);

  // High only in the wait cycle of a request. Combinational so that a
  // request is stalled in the very cycle it appears; a registered
  // stall would let the first edge complete an access unseen
  assign avs_waitrequest = req && (bus_state == BUS_IDLE);

  // Handshake next state
  always_comb begin
    next_bus_state = BUS_IDLE;
    case (bus_state)
      BUS_IDLE: begin
        // First cycle of a request waits
        next_bus_state = req ? BUS_DONE : BUS_IDLE;
      end
      BUS_DONE: begin
        // Always return so each access costs two cycles
        next_bus_state = BUS_IDLE;
      end
      default: begin
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  // Handshake state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_state <= BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // Read mux, unused high bits read zero. Masking here as well as on
  // write keeps the read side right even if a counter ever carries
  // garbage in its upper bits, e.g. straight after power-up
  always_comb begin
    rd_val = BCD_ZERO;
    case (avs_address)
      // Stage view top bit is tied to zero
      OFS_PRESCALER: rd_val = {1'b0, pif.view};
      OFS_SECONDS:   rd_val = seconds_bcd & MASK_SEC;
      OFS_MINUTES:   rd_val = minutes_bcd & MASK_MIN;
      OFS_HOURS:     rd_val = hours_bcd & MASK_HOUR;
      OFS_WEEKDAY:   rd_val = weekday_code & MASK_WEEK;
      OFS_DATE:      rd_val = date_bcd & MASK_DATE;
      OFS_MONTH:     rd_val = month_bcd & MASK_MONTH;
      OFS_YEAR:      rd_val = year_bcd & MASK_YEAR;
      OFS_CONTROL: begin
        // Only the run bit reads back; action bits read zero
        rd_val[CTL_RUN_BIT] = run;
      end
      default: begin
        // Unmapped offsets read zero
        rd_val = BCD_ZERO;
      end
    endcase
  end

  // Read data captured in the wait cycle, stable when answered.
  // A counter that ticks during the answering cycle is not seen;
  // software reads the value of the edge before
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= '0;
    end else if (avs_read && bus_state == BUS_IDLE) begin
      avs_readdata <= {{(DATA_W - 8){1'b0}}, rd_val};
    end
  end

  // Run bit; counting is on after reset. Clearing it also freezes the
  // divider, so a stop and restart loses no fraction of a step
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run <= CTL_RUN_RESET;
    end else if (ctl_wr) begin
      run <= wbyte[CTL_RUN_BIT];
    end
  end

  // Action bits as one-cycle pulses; they act one cycle after the
  // write edge, which keeps the clear off the bus-decode path
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_rst <= 1'b0;
      round   <= 1'b0;
    end else begin
      clk_rst <= ctl_wr && wbyte[CTL_CLKRST_BIT];
      round   <= ctl_wr && wbyte[CTL_ROUND_BIT];
    end
  end

  // Calendar arithmetic and software writes. The whole carry chain
  // ripples in one cycle: a second carry can turn over the year in
  // a single edge. Long path, but the clock is slow next to it
  always_comb begin
    logic [8:0] s;
    s            = '0;
    next_seconds = seconds_bcd;
    next_minutes = minutes_bcd;
    next_hours   = hours_bcd;
    next_weekday = weekday_code;
    next_date    = date_bcd;
    next_month   = month_bcd;
    next_year    = year_bcd;
    min_in       = 1'b0;
    hour_in      = 1'b0;
    day_in       = 1'b0;
    mon_in       = 1'b0;
    yr_in        = 1'b0;
    // Leap and last day come from the stored year and month
    leap         = rtcc_is_leap(year_bcd);
    last_day     = rtcc_last_day(month_bcd, leap);
    sec_in       = pif.carry;

    // Rounding: below 30 s drop seconds, else round up a minute
    if (round) begin
      next_seconds = BCD_ZERO;
      min_in       = (seconds_bcd >= SEC_HALF);
    end else if (sec_in) begin
      s            = rtcc_step(seconds_bcd, SEC_MAX, BCD_ZERO);
      next_seconds = s[7:0];
      min_in       = s[8];
    end

    if (min_in) begin
      s            = rtcc_step(minutes_bcd, MIN_MAX, BCD_ZERO);
      next_minutes = s[7:0];
      hour_in      = s[8];
    end

    // No twelve-hour mode; hours always run 00 to 23
    if (hour_in) begin
      s          = rtcc_step(hours_bcd, HOUR_MAX, BCD_ZERO);
      next_hours = s[7:0];
      day_in     = s[8];
    end

    if (day_in) begin
      s            = rtcc_step(weekday_code, WEEK_MAX, BCD_ZERO);
      next_weekday = s[7:0];
      // Weekday has no tie to the date; both follow the day carry.
      // Date tops out at the month's own last day
      s            = rtcc_step(date_bcd, last_day, BCD_ONE);
      next_date    = s[7:0];
      mon_in       = s[8];
    end

    if (mon_in) begin
      // A month of 00 steps to 01 like any other value
      s          = rtcc_step(month_bcd, MONTH_MAX, BCD_ONE);
      next_month = s[7:0];
      yr_in      = s[8];
    end

    // The year wraps 99 to 00, which counts as leap again
    if (yr_in) begin
      s         = rtcc_step(year_bcd, YEAR_MAX, BCD_ZERO);
      next_year = s[7:0];
    end

    // A write wins over a carry in the same cycle; software is
    // expected to stop counting first, so this only matters for
    // the hours carry-check method
    if (wr_fire) begin
      case (avs_address)
        OFS_SECONDS: next_seconds = wbyte & MASK_SEC;
        OFS_MINUTES: next_minutes = wbyte & MASK_MIN;
        OFS_HOURS:   next_hours   = wbyte & MASK_HOUR;
        OFS_WEEKDAY: next_weekday = wbyte & MASK_WEEK;
        OFS_DATE:    next_date    = wbyte & MASK_DATE;
        OFS_MONTH:   next_month   = wbyte & MASK_MONTH;
        OFS_YEAR:    next_year    = wbyte & MASK_YEAR;
        default: begin
          // Other offsets leave the counters alone
          next_year = next_year;
        end
      endcase
    end
  end

  // Counters: no reset at all, contents ride through any reset.
  // Out-of-range values written by software give no defined
  // sequence; nothing here repairs them
  // Simulation shows them unknown until software first writes them
  always_ff @(posedge clk) begin
    seconds_bcd  <= next_seconds;
    minutes_bcd  <= next_minutes;
    hours_bcd    <= next_hours;
    weekday_code <= next_weekday;
    date_bcd     <= next_date;
    month_bcd    <= next_month;
    year_bcd     <= next_year;
  end

endmodule

//--- rtcc_counter_chain_properties.sv
`timescale 1ns/100ps
// Bus-side checks of the calendar counter chain
module rtcc_chain_props
  import rtcc_pkg::*;
#(
  parameter int STEP_CYCLES_P = STEP_CYCLES
) (
  input wire logic              clk,
  input wire logic              arst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic              avs_waitrequest
);
  // Read completing at this edge, and its byte lane
  wire logic       rd_done = avs_read && !avs_waitrequest;
  wire logic [7:0] rd_byte = avs_readdata[7:0];

  // One clock domain, so shared clocking and reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Fresh request always sees a wait cycle first
  property p_wait_first;
    $rose(avs_read || avs_write) |-> avs_waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait cycle");
  // Exactly one wait cycle, never a stall
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait too long");
  // Unused lanes read zero
  property p_high_zero;
    rd_done |-> avs_readdata[31:8] == 24'h0;
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("upper lanes set");
  // Stage view top bit is zero
  property p_view_top;
    rd_done && avs_address == OFS_PRESCALER |-> !rd_byte[7];
  endproperty
  a_view_top: assert property (p_view_top) else $error("view bit 7 set");
  // Seconds stay in range
  property p_sec_range;
    rd_done && avs_address == OFS_SECONDS |-> rd_byte <= SEC_MAX;
  endproperty
  a_sec_range: assert property (p_sec_range) else $error("seconds range");
  // Units digit is decimal
  property p_sec_bcd;
    rd_done && avs_address == OFS_SECONDS |-> rd_byte[3:0] <= DIGIT_NINE;
  endproperty
  a_sec_bcd: assert property (p_sec_bcd) else $error("seconds not bcd");
  // Minutes stay in range
  property p_min_range;
    rd_done && avs_address == OFS_MINUTES |-> rd_byte <= MIN_MAX;
  endproperty
  a_min_range: assert property (p_min_range) else $error("minutes range");
  // Hours stay in range
  property p_hour_range;
    rd_done && avs_address == OFS_HOURS |-> rd_byte <= HOUR_MAX;
  endproperty
  a_hour_range: assert property (p_hour_range) else $error("hours range");
  // Weekday stays in range
  property p_week_range;
    rd_done && avs_address == OFS_WEEKDAY |-> rd_byte <= WEEK_MAX;
  endproperty
  a_week_range: assert property (p_week_range) else $error("weekday range");
  // Date never zero, never past 31
  property p_date_range;
    rd_done && avs_address == OFS_DATE |-> rd_byte inside {[BCD_ONE:DAYS_31]};
  endproperty
  a_date_range: assert property (p_date_range) else $error("date range");
  // Month stays in range
  property p_month_range;
    rd_done && avs_address == OFS_MONTH |-> rd_byte <= MONTH_MAX;
  endproperty
  a_month_range: assert property (p_month_range) else $error("month range");
endmodule

bind rtcc_counter_chain rtcc_chain_props #(.STEP_CYCLES_P(STEP_CYCLES_P)) u_props (
  .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

//--- tb_top.sv
`timescale 1ns/100ps
// Self-checking bench for the calendar counter chain
module tb_top
  import rtcc_pkg::*;
;
  localparam int STEPS   = 4;           // Short prescaler step
  localparam int ONE_SEC = 128 * STEPS; // Cycles per second carry
  localparam int LIMIT   = 12000;       // Watchdog ceiling

  logic              clk;
  logic              arst_n;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [DATA_W-1:0] avs_writedata;
  logic [3:0]        avs_byteenable;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  int                n_errors = 0;  // Mismatch count
  int                tests_run = 0; // Comparison count
  int                cycles = 0;    // Watchdog count
  logic [7:0]        rd;            // Last read byte

  // Start values {year,month,date,week,hour,min,sec} and one second later
  logic [55:0] set_t [8] = '{56'h03022806235959, 56'h04022806235959,
    56'h00022902235959, 56'h99123103235959, 56'h21043005235959,
    56'h45071501125919, 56'h45071501095959, 56'h45093001235959};
  logic [55:0] exp_t [8] = '{56'h03030100000000, 56'h04022900000000,
    56'h00030103000000, 56'h00010104000000, 56'h21050106000000,
    56'h45071501125920, 56'h45071501100000, 56'h45100102000000};

  // Device under test
  rtcc_counter_chain #(.STEP_CYCLES_P(STEPS)) dut (
    .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Watchdog against a hung handshake
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      stop_test();
    end
  end

  // Verdict and end of run
  task automatic stop_test();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Byte comparison
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Avalon write; held until waitrequest low at an edge
  task automatic bus_write(input logic [5:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write      <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  // Avalon read; data taken at the completing edge
  task automatic bus_read(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata[7:0];
    avs_read <= 1'b0;
  endtask

  // Stop and clear the divider, then check view and pulse bits
  task automatic s_init();
    bus_write(OFS_CONTROL, 8'h02, 4'h1);
    bus_read(OFS_PRESCALER, rd);
    check8(rd, 8'h00);
    bus_read(OFS_CONTROL, rd);
    check8(rd, 8'h00);
  endtask

  // Rollover table: set while stopped, run one second, stop, read back
  task automatic s_tick();
    int t0;  // Cycles spent running
    for (int c = 0; c < 8; c++) begin
      bus_write(OFS_CONTROL, 8'h02, 4'h1);
      for (int i = 0; i < 7; i++) begin
        bus_write(OFS_SECONDS + 6'(4 * i), set_t[c][8*i +: 8], 4'h1);
      end
      bus_write(OFS_CONTROL, 8'h01, 4'h1);
      t0 = cycles;
      repeat (ONE_SEC + 40) @(posedge clk);
      bus_write(OFS_CONTROL, 8'h00, 4'h1);
      t0 = cycles - t0;
      // One stage step per STEPS running cycles, seven binary stages
      bus_read(OFS_PRESCALER, rd);
      check8(rd, 8'((t0 / STEPS) % 128));
      for (int i = 0; i < 7; i++) begin
        bus_read(OFS_SECONDS + 6'(4 * i), rd);
        check8(rd, exp_t[c][8*i +: 8]);
      end
    end
  endtask

  // Half-minute rounding up and down; also clears a stopped view
  task automatic s_round();
    bus_write(OFS_SECONDS, 8'h45, 4'h1);
    bus_write(OFS_MINUTES, 8'h10, 4'h1);
    bus_write(OFS_CONTROL, 8'h04, 4'h1);
    bus_read(OFS_PRESCALER, rd);
    check8(rd, 8'h00);
    bus_read(OFS_SECONDS, rd);
    check8(rd, 8'h00);
    bus_read(OFS_MINUTES, rd);
    check8(rd, 8'h11);
    bus_write(OFS_SECONDS, 8'h15, 4'h1);
    bus_write(OFS_CONTROL, 8'h04, 4'h1);
    bus_read(OFS_SECONDS, rd);
    check8(rd, 8'h00);
    bus_read(OFS_MINUTES, rd);
    check8(rd, 8'h11);
  endtask

  // Reset while stopped keeps counters, restores run bit
  task automatic s_reset();
    bus_write(OFS_SECONDS, 8'h33, 4'h1);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    bus_read(OFS_SECONDS, rd);
    check8(rd, 8'h33);
    bus_read(OFS_MINUTES, rd);
    check8(rd, 8'h11);
    bus_read(OFS_CONTROL, rd);
    check8(rd, 8'h01);
    // Hours written while running, well clear of any carry
    bus_write(OFS_HOURS, 8'h07, 4'h1);
    bus_read(OFS_HOURS, rd);
    check8(rd, 8'h07);
    bus_write(OFS_CONTROL, 8'h00, 4'h1);
  endtask

  // Unmapped place, disabled lane, full-width year
  task automatic s_refuse();
    bus_write(6'h24, 8'h5A, 4'h1);
    bus_read(6'h24, rd);
    check8(rd, 8'h00);
    bus_write(OFS_YEAR, 8'h77, 4'h0);
    bus_read(OFS_YEAR, rd);
    check8(rd, 8'h45);
    bus_write(OFS_YEAR, 8'h77, 4'h1);
    bus_read(OFS_YEAR, rd);
    check8(rd, 8'h77);
  endtask

  // Main sequence
  initial begin
    arst_n         = 1'b0;
    avs_address    = '0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = '0;
    avs_byteenable = 4'h0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    s_init();
    s_tick();
    s_round();
    s_reset();
    s_refuse();
    stop_test();
  end
endmodule
